//--- rtl/uart_core_defines.svh
`ifndef UART_CORE_DEFINES_SVH
`define UART_CORE_DEFINES_SVH

// control register fields
`define CTL_WIDTH        4
`define CTL_MODULE_EN    0
`define CTL_TX_EN        1
`define CTL_RX_EN        2
`define CTL_IR_EN        3
`define CTL_RESET        4'h6

// line control fields
`define LCR_WIDTH        8
`define LCR_BREAK        0
`define LCR_PARITY_EN    1
`define LCR_EVEN         2
`define LCR_STOP2        3
`define LCR_QUEUE_EN     4
`define LCR_LEN_LO       5
`define LCR_LEN_HI       6
`define LCR_STICK        7

// working register layout: integer, fraction, line control
`define WORK_WIDTH       30
`define WORK_RESET       30'h00000000
`define WORK_LCR_HI      7
`define WORK_DIV_LO      8
`define WORK_DIV_HI      29
`define INT_WIDTH        16
`define FRAC_WIDTH       6
`define DIV_WIDTH        22
`define ACC_WIDTH        23
`define ACC_STEP         23'h000040

// queues
`define QUEUE_DEPTH      16
`define TX_WIDTH         8
`define RX_WIDTH         12
`define RX_FRAMING       8
`define RX_PARITY        9
`define RX_BREAK         10
`define RX_OVERRUN       11

// oversample tick positions
`define TICK_START_CHECK 4'h7
`define TICK_LAST        4'hf
`define IR_PULSE_TICKS   4'h3
`define IR_HOLD_TICKS    4'hf

`endif

//--- rtl/uart_core_pkg.sv
package uart_core_pkg;

   typedef enum logic [4:0] {
      TX_IDLE   = 5'h01,
      TX_START  = 5'h02,
      TX_DATA   = 5'h04,
      TX_PARITY = 5'h08,
      TX_STOP   = 5'h10
   } tx_state_type;

   typedef enum logic [4:0] {
      RX_IDLE   = 5'h01,
      RX_START  = 5'h02,
      RX_DATA   = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP   = 5'h10
   } rx_state_type;

endpackage

//--- rtl/uart_queue.sv
`timescale 1ns/1ps
`default_nettype none

module uart_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             singleEntry,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int ABITS = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [ABITS-1:0] wrPtr_reg;
   logic [ABITS-1:0] rdPtr_reg;
   logic [ABITS:0]   count_reg;
   logic [ABITS:0]   count_next;
   logic             inReady_reg;
   logic             outValid_reg;
   logic             push;
   logic             pop;

   assign push = inValid & inReady_reg;
   assign pop = outReady & outValid_reg;
   assign inReady = inReady_reg;
   assign outValid = outValid_reg;
   assign outData = mem[rdPtr_reg];

   always_comb begin
      count_next = count_reg;
      if (push & ~pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop & ~push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   // flags registered from the next count so both ports see flop outputs
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wrPtr_reg    <= '0;
         rdPtr_reg    <= '0;
         count_reg    <= '0;
         inReady_reg  <= 1'b1;
         outValid_reg <= 1'b0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == ABITS'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == ABITS'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
         end
         count_reg    <= count_next;
         inReady_reg  <= (count_next != (ABITS+1)'(DEPTH))
                         & ~(singleEntry & (count_next != '0));
         outValid_reg <= (count_next != '0);
      end
   end

endmodule

`default_nettype wire

//--- rtl/uart_tx_rx_baud_core.sv
// Contract
// - separate transmit/receive enables, both set at reset
// - disabling mid-character finishes that character
// - start, data lsb first, parity, stop
// - receive overrun, parity, framing, break flags stored
// - divisor is 16.6 fixed-point tick period (one sixteenth of a bit)
// - divisor equals clock over sixteen baud
// - sixteen-times tick; transmit bit is sixteen ticks
// - 30-bit working register loads on line-control write
// - two 16-entry queues; receive adds four status
// - queued character starts frames, back to back
// - busy until queue empty and shifter done
// - falling edge starts; valid if low tick eight
// - data sampled every 16 ticks, then parity
// - stop bit high else framing error
// - infrared mode modulates the transmit pin, stretches receive pulses
// - zero sends 3/16 high pulse, one low
// - queues single-entry until queue enable set
// - read gives 12 bits, write takes 8
// - five to eight bits, parity kinds, stops
`include "uart_core_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_tx_rx_baud_core (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire logic                     controlWrite,
   input  wire logic [`CTL_WIDTH-1:0]    controlIn,
   input  wire logic                     integerDivisorWrite,
   input  wire logic [`INT_WIDTH-1:0]    integerDivisorIn,
   input  wire logic                     fractionalDivisorWrite,
   input  wire logic [`FRAC_WIDTH-1:0]   fractionalDivisorIn,
   input  wire logic                     lineControlWrite,
   input  wire logic [`LCR_WIDTH-1:0]    lineControlIn,
   input  wire logic [`TX_WIDTH-1:0]     txData,
   input  wire logic                     txValid,
   output logic                          txReady,
   output logic      [`RX_WIDTH-1:0]     rxData,
   output logic                          rxValid,
   input  wire logic                     rxReady,
   input  wire logic                     serialRxPin,
   output logic                          serialTxPin,
   output logic                          busy,
   output logic      [`CTL_WIDTH-1:0]    controlState
);
   import uart_core_pkg::*;

   logic [`CTL_WIDTH-1:0]  control_reg;
   logic [`INT_WIDTH-1:0]  intDivisor_reg;
   logic [`FRAC_WIDTH-1:0] fracDivisor_reg;
   logic [`WORK_WIDTH-1:0] work_reg;
   logic [`ACC_WIDTH-1:0]  baudAcc_reg;
   logic [`ACC_WIDTH-1:0]  baudSum;
   logic [`DIV_WIDTH-1:0]  divisor;
   logic                   tick_reg;
   logic [`LCR_WIDTH-1:0]  lineCtl;
   logic [2:0]             lastBit;
   logic                   irMode;
   logic                   txEnabled;
   logic                   rxEnabled;

   assign lineCtl = work_reg[`WORK_LCR_HI:0];
   assign divisor = work_reg[`WORK_DIV_HI:`WORK_DIV_LO];
   assign lastBit = {1'b1, lineCtl[`LCR_LEN_HI:`LCR_LEN_LO]};
   assign irMode = control_reg[`CTL_IR_EN];
   assign txEnabled = control_reg[`CTL_MODULE_EN] & control_reg[`CTL_TX_EN];
   assign rxEnabled = control_reg[`CTL_MODULE_EN] & control_reg[`CTL_RX_EN];
   assign controlState = control_reg;

   // parity over the configured length; stick forces a constant level
   function automatic logic parityOf(input logic [7:0] data, input logic [2:0] lastIdx,
                                     input logic even, input logic stick);
      logic [7:0] mask;
      logic       odd;
      mask = 8'hff >> (3'h7 - lastIdx);
      odd = ^(data & mask);
      if (stick) begin
         parityOf = ~even;
      end else begin
         parityOf = even ? odd : ~odd;
      end
   endfunction

   // settings; software keeps the module disabled while these change
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         control_reg     <= `CTL_RESET;
         intDivisor_reg  <= '0;
         fracDivisor_reg <= '0;
         work_reg        <= `WORK_RESET;
      end else begin
         if (controlWrite) begin
            control_reg <= controlIn;
         end
         if (integerDivisorWrite) begin
            intDivisor_reg <= integerDivisorIn;
         end
         if (fractionalDivisorWrite) begin
            fracDivisor_reg <= fractionalDivisorIn;
         end
         if (lineControlWrite) begin
            work_reg <= {intDivisor_reg, fracDivisor_reg, lineControlIn};
         end
      end
   end

   // accumulate 64ths of a clock against the divisor
   assign baudSum = baudAcc_reg + `ACC_STEP;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         baudAcc_reg <= '0;
         tick_reg    <= 1'b0;
      end else if (divisor == '0) begin
         baudAcc_reg <= '0;
         tick_reg    <= 1'b0;
      end else if (baudSum >= {1'b0, divisor}) begin
         baudAcc_reg <= baudSum - {1'b0, divisor};
         tick_reg    <= 1'b1;
      end else begin
         baudAcc_reg <= baudSum;
         tick_reg    <= 1'b0;
      end
   end

   // transmit
   tx_state_type          txState_reg;
   logic [3:0]            txTick_reg;
   logic [2:0]            txBit_reg;
   logic [7:0]            txShift_reg;
   logic                  txParity_reg;
   logic                  txSecondStop_reg;
   logic                  txLine_reg;
   logic                  busy_reg;
   logic [`TX_WIDTH-1:0]  txQueueData;
   logic                  txQueueValid;
   logic                  txPop;
   logic                  txLevel;
   logic                  txBitDone;

   assign txPop = (txState_reg == TX_IDLE) & txQueueValid & txEnabled;
   assign txBitDone = tick_reg & (txTick_reg == `TICK_LAST);

   uart_queue #(
      .WIDTH(`TX_WIDTH),
      .DEPTH(`QUEUE_DEPTH)
   ) txQueue (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .singleEntry(~lineCtl[`LCR_QUEUE_EN]),
      .inData     (txData),
      .inValid    (txValid),
      .inReady    (txReady),
      .outData    (txQueueData),
      .outValid   (txQueueValid),
      .outReady   (txPop)
   );

   // a started frame runs to its last stop bit
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txState_reg      <= TX_IDLE;
         txTick_reg       <= '0;
         txBit_reg        <= '0;
         txShift_reg      <= '0;
         txParity_reg     <= 1'b0;
         txSecondStop_reg <= 1'b0;
      end else begin
         if (tick_reg && txState_reg != TX_IDLE) begin
            txTick_reg <= txTick_reg + 1'b1;
         end
         case (txState_reg)
            TX_IDLE: begin
               if (txPop) begin
                  txShift_reg      <= txQueueData;
                  txParity_reg     <= parityOf(txQueueData, lastBit,
                                               lineCtl[`LCR_EVEN], lineCtl[`LCR_STICK]);
                  txTick_reg       <= '0;
                  txBit_reg        <= '0;
                  txSecondStop_reg <= 1'b0;
                  txState_reg      <= TX_START;
               end
            end
            TX_START: begin
               if (txBitDone) begin
                  txState_reg <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (txBitDone) begin
                  txShift_reg <= {1'b0, txShift_reg[7:1]};
                  txBit_reg   <= txBit_reg + 1'b1;
                  if (txBit_reg == lastBit) begin
                     txState_reg <= lineCtl[`LCR_PARITY_EN] ? TX_PARITY : TX_STOP;
                  end
               end
            end
            TX_PARITY: begin
               if (txBitDone) begin
                  txState_reg <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (txBitDone) begin
                  if (lineCtl[`LCR_STOP2] && !txSecondStop_reg) begin
                     txSecondStop_reg <= 1'b1;
                  end else begin
                     txState_reg <= TX_IDLE;
                  end
               end
            end
            default: begin
               txState_reg <= TX_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      case (txState_reg)
         TX_START:  txLevel = 1'b0;
         TX_DATA:   txLevel = txShift_reg[0];
         TX_PARITY: txLevel = txParity_reg;
         default:   txLevel = 1'b1;
      endcase
      if (lineCtl[`LCR_BREAK]) begin
         txLevel = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txLine_reg <= 1'b1;
         busy_reg   <= 1'b0;
      end else begin
         if (irMode) begin
            txLine_reg <= ~txLevel & (txTick_reg < `IR_PULSE_TICKS)
                          & (txState_reg != TX_IDLE);
         end else begin
            txLine_reg <= txLevel;
         end
         busy_reg <= (txValid & txReady) | txQueueValid | (txState_reg != TX_IDLE);
      end
   end

   assign serialTxPin = txLine_reg;
   assign busy = busy_reg;

   // receive
   rx_state_type          rxState_reg;
   logic                  rxMeta_reg;
   logic                  rxSync_reg;
   logic                  rxLine_reg;
   logic                  rxLinePrev_reg;
   logic [3:0]            irHold_reg;
   logic [3:0]            rxTick_reg;
   logic [2:0]            rxBit_reg;
   logic [7:0]            rxShift_reg;
   logic                  rxParityErr_reg;
   logic                  rxAllZero_reg;
   logic                  rxPush_reg;
   logic [`RX_WIDTH-1:0]  rxPushData_reg;
   logic                  overrun_reg;
   logic                  rxQueueReady;
   logic                  rxSample;

   assign rxSample = tick_reg & (rxTick_reg == `TICK_LAST);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxMeta_reg     <= 1'b1;
         rxSync_reg     <= 1'b1;
         rxLine_reg     <= 1'b1;
         rxLinePrev_reg <= 1'b1;
         irHold_reg     <= '0;
      end else begin
         rxMeta_reg     <= serialRxPin;
         rxSync_reg     <= rxMeta_reg;
         rxLinePrev_reg <= rxLine_reg;
         // a short infrared low pulse is stretched to roughly one bit
         if (irMode && !rxSync_reg) begin
            irHold_reg <= `IR_HOLD_TICKS;
         end else if (tick_reg && irHold_reg != '0) begin
            irHold_reg <= irHold_reg - 1'b1;
         end
         if (irMode) begin
            rxLine_reg <= rxSync_reg & (irHold_reg == '0);
         end else begin
            rxLine_reg <= rxSync_reg;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxState_reg     <= RX_IDLE;
         rxTick_reg      <= '0;
         rxBit_reg       <= '0;
         rxShift_reg     <= '0;
         rxParityErr_reg <= 1'b0;
         rxAllZero_reg   <= 1'b0;
         rxPush_reg      <= 1'b0;
         rxPushData_reg  <= '0;
      end else begin
         rxPush_reg <= 1'b0;
         if (tick_reg && rxState_reg != RX_IDLE) begin
            rxTick_reg <= rxTick_reg + 1'b1;
         end
         case (rxState_reg)
            RX_IDLE: begin
               if (rxEnabled && rxLinePrev_reg && !rxLine_reg) begin
                  rxTick_reg      <= '0;
                  rxBit_reg       <= '0;
                  rxShift_reg     <= '0;
                  rxParityErr_reg <= 1'b0;
                  rxAllZero_reg   <= 1'b1;
                  rxState_reg     <= RX_START;
               end
            end
            RX_START: begin
               if (tick_reg && rxTick_reg == `TICK_START_CHECK) begin
                  if (!rxLine_reg) begin
                     rxTick_reg  <= '0;
                     rxState_reg <= RX_DATA;
                  end else begin
                     rxState_reg <= RX_IDLE;
                  end
               end
            end
            RX_DATA: begin
               if (rxSample) begin
                  rxShift_reg[rxBit_reg] <= rxLine_reg;
                  rxAllZero_reg          <= rxAllZero_reg & ~rxLine_reg;
                  rxBit_reg              <= rxBit_reg + 1'b1;
                  if (rxBit_reg == lastBit) begin
                     rxState_reg <= lineCtl[`LCR_PARITY_EN] ? RX_PARITY : RX_STOP;
                  end
               end
            end
            RX_PARITY: begin
               if (rxSample) begin
                  rxParityErr_reg <= rxLine_reg != parityOf(rxShift_reg, lastBit,
                                        lineCtl[`LCR_EVEN], lineCtl[`LCR_STICK]);
                  rxAllZero_reg   <= rxAllZero_reg & ~rxLine_reg;
                  rxState_reg     <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rxSample) begin
                  rxPush_reg                  <= 1'b1;
                  rxPushData_reg[7:0]         <= rxShift_reg;
                  rxPushData_reg[`RX_FRAMING] <= ~rxLine_reg;
                  rxPushData_reg[`RX_PARITY]  <= rxParityErr_reg;
                  rxPushData_reg[`RX_BREAK]   <= rxAllZero_reg & ~rxLine_reg;
                  rxPushData_reg[`RX_OVERRUN] <= overrun_reg;
                  rxState_reg                 <= RX_IDLE;
               end
            end
            default: begin
               rxState_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // a character lost to a full queue flags the next stored one
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         overrun_reg <= 1'b0;
      end else if (rxPush_reg) begin
         overrun_reg <= ~rxQueueReady;
      end
   end

   uart_queue #(
      .WIDTH(`RX_WIDTH),
      .DEPTH(`QUEUE_DEPTH)
   ) rxQueue (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .singleEntry(~lineCtl[`LCR_QUEUE_EN]),
      .inData     (rxPushData_reg),
      .inValid    (rxPush_reg),
      .inReady    (rxQueueReady),
      .outData    (rxData),
      .outValid   (rxValid),
      .outReady   (rxReady)
   );

endmodule

`default_nettype wire

//--- testbench/uart_core_asserts.sv
`include "uart_core_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_core_asserts (
   input wire logic                  clk_sys,
   input wire logic                  reset,
   input wire logic                  controlWrite,
   input wire logic [`CTL_WIDTH-1:0] controlIn,
   input wire logic                  lineControlWrite,
   input wire logic [`LCR_WIDTH-1:0] lineControlIn,
   input wire logic                  txValid,
   input wire logic                  txReady,
   input wire logic [`RX_WIDTH-1:0]  rxData,
   input wire logic                  rxValid,
   input wire logic                  rxReady,
   input wire logic                  serialTxPin,
   input wire logic                  busy,
   input wire logic [`CTL_WIDTH-1:0] controlState
);
   logic sendBreak_reg;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   // break forces the pin low outside infrared mode
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sendBreak_reg <= 1'b0;
      end else if (lineControlWrite) begin
         sendBreak_reg <= lineControlIn[`LCR_BREAK];
      end
   end

   property p_reset_values;
      $fell(reset) |-> controlState == `CTL_RESET && serialTxPin && !busy && txReady && !rxValid;
   endproperty
   property p_ctl_copy;
      controlWrite |=> controlState == $past(controlIn);
   endproperty
   property p_busy_on_push;
      txValid && txReady |=> busy;
   endproperty
   // three settled cycles hide the pin lag
   property p_low_means_busy;
      (!controlState[`CTL_IR_EN] && !sendBreak_reg)[*3] ##0 !serialTxPin |-> busy;
   endproperty
   property p_idle_high;
      (!busy && !controlState[`CTL_IR_EN] && !sendBreak_reg)[*3] |-> serialTxPin;
   endproperty
   property p_ir_idle;
      (!busy && controlState[`CTL_IR_EN])[*3] |-> !serialTxPin;
   endproperty
   property p_rx_hold;
      rxValid && !rxReady |=> rxValid && $stable(rxData);
   endproperty
   property p_full_busy;
      !txReady |-> busy;
   endproperty

   a_reset_values: assert property (p_reset_values) else $error("reset state wrong");
   a_ctl_copy: assert property (p_ctl_copy) else $error("control copy wrong");
   a_busy_on_push: assert property (p_busy_on_push) else $error("busy late");
   a_low_means_busy: assert property (p_low_means_busy) else $error("pin low idle");
   a_idle_high: assert property (p_idle_high) else $error("idle pin not high");
   a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");
   a_rx_hold: assert property (p_rx_hold) else $error("receive head moved");
   a_full_busy: assert property (p_full_busy) else $error("full but not busy");

   c_push: cover property (txValid && txReady);
   c_pop: cover property (rxValid && rxReady);
   c_full: cover property (!txReady && busy);
endmodule

bind uart_tx_rx_baud_core uart_core_asserts uart_core_asserts_inst (.*);

`default_nettype wire

//--- testbench/uart_remote_model.sv
`timescale 1ns/1ps
`default_nettype none

module uart_remote_model (
   input  wire logic clk_sys,
   output logic      serialRxPin
);
   initial serialRxPin = 1'b1;

   // lsb first, then idle high for one bit
   task automatic sendFrame(input logic [15:0] bits, input int n, input int bc);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         serialRxPin <= bits[i];
         repeat (bc - 1) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      serialRxPin <= 1'b1;
      repeat (bc) @(posedge clk_sys);
   endtask
endmodule

`default_nettype wire

//--- testbench/uart_tx_rx_baud_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uart_tx_rx_baud_core_tb;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        controlWrite = 1'b0;
   logic [3:0]  controlIn = 4'h6;
   logic        integerDivisorWrite = 1'b0;
   logic [15:0] integerDivisorIn = 16'h1;
   logic        fractionalDivisorWrite = 1'b0;
   logic [5:0]  fractionalDivisorIn = 6'h00;
   logic        lineControlWrite = 1'b0;
   logic [7:0]  lineControlIn = 8'h70;
   logic [7:0]  txData = 8'h00;
   logic        txValid = 1'b0;
   logic        txReady;
   logic [11:0] rxData;
   logic        rxValid;
   logic        rxReady = 1'b0;
   logic        serialRxPin;
   logic        serialTxPin;
   logic        busy;
   logic [3:0]  controlState;
   int          numErrors = 0;
   int          testsRun = 0;

   uart_tx_rx_baud_core uart_tx_rx_baud_core_inst (.*);
   uart_remote_model uart_remote_model_inst (.*);

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      testsRun++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] frameOf(input logic [7:0] d, input logic [7:0] lcr);
      int          len;
      logic [15:0] f;
      logic        p;
      len = 5 + int'(lcr[6:5]);
      f = 16'hfffe;
      p = ~lcr[2];
      for (int i = 0; i < len; i++) begin
         f[i + 1] = d[i];
         p ^= d[i];
      end
      if (lcr[7]) p = ~lcr[2];
      if (lcr[1]) f[len + 1] = p;
      return f;
   endfunction

   task automatic ctl(input logic [3:0] v);
      @(posedge clk_sys);
      controlWrite <= 1'b1;
      controlIn <= v;
      @(posedge clk_sys);
      controlWrite <= 1'b0;
   endtask

   task automatic cfg(input logic [3:0] c, input logic [15:0] di, input logic [5:0] df,
                      input logic [7:0] lcr, input logic apply);
      ctl({c[3:1], 1'b0});
      @(posedge clk_sys);
      integerDivisorWrite <= 1'b1;
      integerDivisorIn <= di;
      fractionalDivisorWrite <= 1'b1;
      fractionalDivisorIn <= df;
      @(posedge clk_sys);
      integerDivisorWrite <= 1'b0;
      fractionalDivisorWrite <= 1'b0;
      lineControlWrite <= apply;
      lineControlIn <= lcr;
      @(posedge clk_sys);
      lineControlWrite <= 1'b0;
      ctl(c);
   endtask

   task automatic push(input logic [7:0] d);
      @(posedge clk_sys);
      txData <= d;
      txValid <= 1'b1;
      @(posedge clk_sys);
      txValid <= 1'b0;
   endtask

   task automatic waitPin(input logic lvl);
      for (int t = 0; t < 4000 && serialTxPin !== lvl; t++) @(negedge clk_sys);
   endtask

   task automatic run(input logic lvl, output int c);
      waitPin(lvl);
      for (c = 0; serialTxPin === lvl && c < 4000; c++) @(negedge clk_sys);
   endtask

   task automatic waitIdle;
      for (int t = 0; t < 4000 && busy !== 1'b0; t++) @(negedge clk_sys);
   endtask

   // mid-bit samples, one tick per clock
   task automatic grab(input int n, output logic [15:0] bits);
      bits = 16'hffff;
      waitPin(1'b0);
      repeat (8) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         bits[i] = serialTxPin;
         if (i < n - 1) repeat (16) @(negedge clk_sys);
      end
   endtask

   task automatic popRx(input string what, input logic [11:0] exp, input logic [11:0] mk);
      for (int t = 0; t < 400 && rxValid !== 1'b1; t++) @(negedge clk_sys);
      chk(what, {4'h1, exp}, {3'h0, rxValid, rxData & mk});
      @(posedge clk_sys);
      rxReady <= 1'b1;
      @(posedge clk_sys);
      rxReady <= 1'b0;
   endtask

   task automatic t_reset;
      chk("ctl reset", 16'h6, controlState);
      chk("pin busy ready valid", 16'ha, {serialTxPin, busy, txReady, rxValid});
   endtask

   task automatic t_formats;
      logic [7:0]  lcrs [5] = '{8'h70, 8'h56, 8'h1a, 8'hf6, 8'h30};
      logic [15:0] got;
      foreach (lcrs[i]) begin
         cfg(4'h7, 16'h1, 6'h00, lcrs[i], 1'b1);
         push(8'hb3);
         grab(12, got);
         chk("frame", frameOf(8'hb3, lcrs[i]), got);
      end
   endtask

   task automatic t_divisor;
      logic [15:0] di [5] = '{16'h1, 16'h2, 16'h1, 16'h2, 16'h2};
      logic [5:0]  df [5] = '{6'h00, 6'h00, 6'h20, 6'h20, 6'h20};
      logic        ap [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      int          w [5] = '{16, 32, 24, 24, 40};
      int          c;
      foreach (di[i]) begin
         cfg(4'h7, di[i], df[i], 8'h70, ap[i]);
         push(8'hfd);
         run(1'b0, c);
         run(1'b0, c);
         chk("bit width", 16'(w[i]), 16'(c));
         waitIdle;
      end
   endtask

   task automatic t_fill;
      logic [15:0] got;
      cfg(4'h6, 16'h1, 6'h00, 8'h70, 1'b1);
      for (int i = 0; i < 16; i++) push(8'h10 + 8'(i));
      repeat (2) @(negedge clk_sys);
      chk("full", 16'h3, {txReady, busy, serialTxPin});
      ctl(4'h7);
      for (int i = 0; i < 16; i++) begin
         grab(10, got);
         chk("queued", frameOf(8'h10 + 8'(i), 8'h70), got);
      end
      waitIdle;
      chk("drained", 16'h0, busy);
   endtask

   task automatic t_single;
      cfg(4'h6, 16'h1, 6'h00, 8'h60, 1'b1);
      push(8'h5a);
      repeat (2) @(negedge clk_sys);
      chk("single", 16'h0, txReady);
      ctl(4'h7);
      waitIdle;
   endtask

   task automatic t_disable;
      logic [15:0] got;
      cfg(4'h7, 16'h1, 6'h00, 8'h70, 1'b1);
      push(8'hc6);
      push(8'h39);
      fork
         grab(10, got);
         begin
            waitPin(1'b0);
            ctl(4'h6);
         end
      join
      chk("frame off", frameOf(8'hc6, 8'h70), got);
      repeat (24) @(negedge clk_sys);
      chk("held", 16'h3, {busy, serialTxPin});
      ctl(4'h7);
      grab(10, got);
      chk("resumed", frameOf(8'h39, 8'h70), got);
      waitIdle;
   endtask

   task automatic t_ir;
      int c;
      cfg(4'hf, 16'h1, 6'h00, 8'h70, 1'b1);
      repeat (4) @(negedge clk_sys);
      chk("ir idle", 16'h0, serialTxPin);
      push(8'hfe);
      run(1'b1, c);
      run(1'b1, c);
      chk("ir pulse", 16'h3, 16'(c));
      waitIdle;
      chk("ir end", 16'h0, serialTxPin);
   endtask

   task automatic t_rx;
      logic [15:0] fr [4] = '{16'h0478, 16'h0678, 16'h0078, 16'h0000};
      logic [11:0] ex [4] = '{12'h03c, 12'h23c, 12'h13c, 12'h400};
      logic [11:0] mk [4] = '{12'hfff, 12'hfff, 12'hfff, 12'h4ff};
      cfg(4'h7, 16'h1, 6'h00, 8'h76, 1'b1);
      uart_remote_model_inst.sendFrame(16'h0000, 1, 4);
      repeat (200) @(negedge clk_sys);
      chk("short low", 16'h0, rxValid);
      foreach (fr[i]) begin
         uart_remote_model_inst.sendFrame(fr[i], 11, 16);
         popRx("rx word", ex[i], mk[i]);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      t_reset;
      t_formats;
      t_divisor;
      t_fill;
      t_single;
      t_disable;
      t_ir;
      t_rx;
      tally_and_finish;
   end

   // run takes about 7k cycles
   initial begin
      #400000;
      numErrors++;
      tally_and_finish;
   end
endmodule

`default_nettype wire
